// >>> src/tpg_pkg.sv
// Operation
// - Overflow request only when flag, its enable and global enable are set.
// - Compare flags A bit 6, B bit 5 set on match; ack or write-one clears.
// - Compare request needs global enable, channel enable and channel flag.
// - Outside PWM, wrap-around sets overflow flag bit 2; clears like others.
// - In PWM mode the top compare match sets the overflow flag.
// - A clear caused by clear-on-compare sets no overflow flag.
// - Reserved flag bits 7, 0 and clock control bits 6..3 read zero.
// - Fast clock runs full rate; low-speed bit halves it.
// - Fast-clock enable picks fast ticks, otherwise system clock ticks.
// - Fast-clock enable can be set only while the PLL is enabled.
// - PLL enable starts PLL and reference; reads one when PLL is sysclk.
// - Lock indicator rises about 100 us after the PLL is enabled.
// - In PWM mode counter runs from 00 to top and restarts at 00.
// - Mode 01: true clears on match, sets at 01; inverse opposite, clears at 00.
// - Modes 10, 11 drive true output only; mode 00 disconnects both.
// - PWM compare writes go to a buffer latched when counter reaches top.
// - Compare reads return the buffered, most recently written value.
// - Compare at 00 or top holds outputs static per mode.
// - Period is top value plus one timer ticks.
// - Each channel has true and inverted outputs, no added dead time.
// - Either channel's PWM enable selects PWM; counter resets the tick after top.
package tpg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PLL_CSR   = 8'h27;
	localparam logic [7:0] IDX_FLAGS     = 8'h38;
	localparam logic [7:0] IDX_MASK      = 8'h39;
	localparam logic [7:0] IDX_CTRL      = 8'h30;
	localparam logic [7:0] IDX_COUNTER   = 8'h2F;
	localparam logic [7:0] IDX_CMP_A     = 8'h2E;
	localparam logic [7:0] IDX_CMP_B     = 8'h2B;
	localparam logic [7:0] IDX_TOP       = 8'h2D;

	// Flag and mask bit positions
	localparam int BIT_CMP_A = 6;
	localparam int BIT_CMP_B = 5;
	localparam int BIT_OVF   = 2;

	// Clock control bit positions
	localparam int BIT_LOW_SPEED = 7;
	localparam int BIT_FAST_EN   = 2;
	localparam int BIT_PLL_EN    = 1;
	localparam int BIT_LOCKED    = 0;

	// Control register layout
	localparam int BIT_CTC     = 7;
	localparam int BIT_PWM_A   = 6;
	localparam int POS_MODE_A  = 4;
	localparam int BIT_PWM_B   = 3;
	localparam int POS_MODE_B  = 0;

	// Reset values
	localparam logic [7:0] RST_TOP = 8'hFF;
	localparam logic [7:0] RST_REG = 8'h00;

	// Lock time
	localparam int CLK_MHZ      = 200;
	localparam int LOCK_TIME_US = 100;
	localparam int LOCK_CYCLES  = LOCK_TIME_US * CLK_MHZ;

	// Output modes
	localparam logic [1:0] MODE_OFF  = 2'h0;
	localparam logic [1:0] MODE_PAIR = 2'h1;
	localparam logic [1:0] MODE_CLR  = 2'h2;
	localparam logic [1:0] MODE_SET  = 2'h3;

	typedef struct packed {
		logic       pwm_en;
		logic [1:0] mode;
	} tpg_chan_t;

	typedef struct packed {
		logic true_out;
		logic true_oe_n;
		logic inv_out;
		logic inv_oe_n;
	} tpg_pins_t;

endpackage

// >>> src/tpg_timer.sv
// Chosen here: register access over APB.
`timescale 1ns/10ps
module tpg_timer
	import tpg_pkg::*;
#(
	parameter int LOCK_CNT = LOCK_CYCLES
)(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timer tick sources
	input  wire logic        sys_tick,
	input  wire logic        pck_tick,
	// Core side
	input  wire logic        global_irq_en,
	input  wire logic        pll_is_sysclk,
	input  wire logic        ack_ovf,
	input  wire logic        ack_cmp_a,
	input  wire logic        ack_cmp_b,
	output logic             irq_ovf,
	output logic             irq_cmp_a,
	output logic             irq_cmp_b,
	// PLL control
	output logic             pll_run,
	output logic             pck_half_rate,
	// PWM pins
	output tpg_pins_t        pins_a,
	output tpg_pins_t        pins_b
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]  counter_value;
	logic [7:0]  compare_a_value;
	logic [7:0]  compare_b_value;
	logic [7:0]  buf_a;
	logic [7:0]  buf_b;
	logic [7:0]  top_compare_value;
	logic [7:0]  ctrl;
	logic [7:0]  timer_interrupt_mask;
	logic        cmp_a_flag;
	logic        cmp_b_flag;
	logic        ovf_flag;
	logic [2:0]  clr_pend;
	logic        low_speed_sel;
	logic        fast_clk_enable;
	logic        pll_en_bit;
	logic        pll_enable;
	logic        pll_locked;
	logic [31:0] lock_cnt;
	logic        half_phase;
	logic        tick;
	logic        pwm_mode;
	logic        at_top;
	logic [7:0]  next_count;
	logic        ev_ovf;
	logic        ev_cmp_a;
	logic        ev_cmp_b;
	logic [2:0]  ev_hold;
	logic [2:0]  ev_flag;
	logic        cnt_written;
	logic        wr;
	logic        rd;
	logic [7:0]  idx;
	logic        mapped;
	logic [7:0]  wdat;
	tpg_chan_t   chan_a;
	tpg_chan_t   chan_b;
	logic [7:0]  eff_a;
	logic [7:0]  eff_b;

	assign wr   = psel && penable && pwrite;
	assign rd   = psel && !penable && !pwrite;
	assign idx  = paddr[9:2];
	assign wdat = pwdata[7:0];

	assign chan_a = '{ctrl[BIT_PWM_A], ctrl[POS_MODE_A +: 2]};
	assign chan_b = '{ctrl[BIT_PWM_B], ctrl[POS_MODE_B +: 2]};
	assign pwm_mode = chan_a.pwm_en || chan_b.pwm_en;

	// Write-one-to-clear bits from the bus data
	function automatic logic [2:0] w1c_bits(input logic [7:0] d);
		w1c_bits = {d[BIT_CMP_A], d[BIT_CMP_B], d[BIT_OVF]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB decode; every access completes in its first access cycle

	assign pready = 1'b1;

	always_comb
	begin
		case (idx)
			IDX_PLL_CSR, IDX_FLAGS, IDX_MASK, IDX_CTRL,
			IDX_COUNTER, IDX_CMP_A, IDX_CMP_B, IDX_TOP:
				mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
			default:
				mapped = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !mapped;

	// Read data loaded in setup so it stands at the access edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd)
		begin
			prdata <= 32'h0000_0000;
			case (idx)
				IDX_PLL_CSR: prdata[7:0] <= {low_speed_sel, 4'h0,
					fast_clk_enable, pll_enable, pll_locked};
				IDX_FLAGS: prdata[7:0] <= {1'b0, cmp_a_flag, cmp_b_flag,
					2'h0, ovf_flag, 2'h0};
				IDX_MASK:    prdata[7:0] <= timer_interrupt_mask;
				IDX_CTRL:    prdata[7:0] <= ctrl;
				IDX_COUNTER: prdata[7:0] <= counter_value;
				IDX_CMP_A:   prdata[7:0] <= buf_a;
				IDX_CMP_B:   prdata[7:0] <= buf_b;
				IDX_TOP:     prdata[7:0] <= top_compare_value;
				default:     prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain control registers

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl                 <= RST_REG;
			timer_interrupt_mask <= RST_REG;
			top_compare_value    <= RST_TOP;
		end
		else if (wr)
		begin
			case (idx)
				IDX_CTRL: ctrl <= wdat;
				IDX_MASK: timer_interrupt_mask <= wdat & ((8'h01 << BIT_CMP_A)
					| (8'h01 << BIT_CMP_B) | (8'h01 << BIT_OVF));
				IDX_TOP:  top_compare_value <= wdat;
				default:  ctrl <= ctrl;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PLL and clock selection

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_speed_sel   <= 1'b0;
			fast_clk_enable <= 1'b0;
			pll_en_bit      <= 1'b0;
		end
		else if (wr && idx == IDX_PLL_CSR)
		begin
			low_speed_sel   <= wdat[BIT_LOW_SPEED];
			pll_en_bit      <= wdat[BIT_PLL_EN];
			// Set refused while PLL is off; clearing always works
			fast_clk_enable <= wdat[BIT_FAST_EN] && pll_enable;
		end
		else if (!pll_enable)
			fast_clk_enable <= 1'b0;
	end

	assign pll_enable = pll_en_bit || pll_is_sysclk;
	assign pll_run = pll_enable;
	assign pck_half_rate = low_speed_sel;

	// Lock is a timer, not a real detector; shorten LOCK_CNT in simulation
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_cnt   <= 32'h0000_0000;
			pll_locked <= 1'b0;
		end
		else if (!pll_enable)
		begin
			lock_cnt   <= 32'h0000_0000;
			pll_locked <= 1'b0;
		end
		else if (lock_cnt >= 32'(LOCK_CNT - 1))
			pll_locked <= 1'b1;
		else
			lock_cnt <= lock_cnt + 32'h0000_0001;
	end

	// Low-speed drops every other fast tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			half_phase <= 1'b0;
		else if (pck_tick)
			half_phase <= !half_phase;
	end

	always_comb
	begin
		if (fast_clk_enable)
			tick = pck_tick && (!low_speed_sel || half_phase);
		else
			tick = sys_tick;
	end

	////////////////////////////////////////////////////////////////////////
	// Counter

	assign at_top = counter_value == top_compare_value;
	assign cnt_written = wr && idx == IDX_COUNTER;

	always_comb
	begin
		next_count = counter_value + 8'h01;
		ev_ovf = 1'b0;
		if (pwm_mode)
		begin
			if (at_top)
			begin
				next_count = 8'h00;
				ev_ovf = 1'b1;
			end
		end
		else if (ctrl[BIT_CTC] && at_top)
			next_count = 8'h00;
		else if (counter_value == 8'hFF)
			ev_ovf = 1'b1;
		ev_ovf = ev_ovf && tick && !cnt_written;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			counter_value <= RST_REG;
		else if (cnt_written)
			counter_value <= wdat;
		else if (tick)
			counter_value <= next_count;
	end

	// A counter write never makes a match in the same cycle
	assign ev_cmp_a = tick && !cnt_written && next_count == compare_a_value;
	assign ev_cmp_b = tick && !cnt_written && next_count == compare_b_value;

	////////////////////////////////////////////////////////////////////////
	// Compare buffers

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_a           <= RST_REG;
			buf_b           <= RST_REG;
			compare_a_value <= RST_REG;
			compare_b_value <= RST_REG;
		end
		else
		begin
			if (wr && idx == IDX_CMP_A)
				buf_a <= wdat;
			if (wr && idx == IDX_CMP_B)
				buf_b <= wdat;
			// Outside PWM the buffer is transparent
			if (!pwm_mode || (tick && at_top))
			begin
				compare_a_value <= buf_a;
				compare_b_value <= buf_b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags; extra stage in fast mode costs one cycle of flag latency

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_hold <= 3'h0;
		else
			ev_hold <= {ev_cmp_a, ev_cmp_b, ev_ovf};
	end

	assign ev_flag = fast_clk_enable ? ev_hold :
		{ev_cmp_a, ev_cmp_b, ev_ovf};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clr_pend <= 3'h0;
		else if (wr && idx == IDX_FLAGS)
			clr_pend <= w1c_bits(wdat);
		else
			clr_pend <= 3'h0;
	end

	// Set wins over both kinds of clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_a_flag <= 1'b0;
			cmp_b_flag <= 1'b0;
			ovf_flag   <= 1'b0;
		end
		else
		begin
			if (ev_flag[2])
				cmp_a_flag <= 1'b1;
			else if (ack_cmp_a || clr_pend[2])
				cmp_a_flag <= 1'b0;
			if (ev_flag[1])
				cmp_b_flag <= 1'b1;
			else if (ack_cmp_b || clr_pend[1])
				cmp_b_flag <= 1'b0;
			if (ev_flag[0])
				ovf_flag <= 1'b1;
			else if (ack_ovf || clr_pend[0])
				ovf_flag <= 1'b0;
		end
	end

	assign irq_ovf = global_irq_en && timer_interrupt_mask[BIT_OVF]
		&& ovf_flag;
	assign irq_cmp_a = global_irq_en && timer_interrupt_mask[BIT_CMP_A]
		&& cmp_a_flag;
	assign irq_cmp_b = global_irq_en && timer_interrupt_mask[BIT_CMP_B]
		&& cmp_b_flag;

	////////////////////////////////////////////////////////////////////////
	// PWM waveform

	// Next true-output level; static cases override edges
	function automatic logic true_next(input logic [1:0] mode,
		input logic [7:0] cmp, input logic [7:0] top, input logic [7:0] nc,
		input logic cur);
		logic inv;
		logic lvl;
		inv = mode == MODE_SET;
		lvl = cur ^ inv;
		if (cmp == 8'h00)
			lvl = 1'b0;
		else if (cmp == top)
			lvl = 1'b1;
		else if (nc == cmp)
			lvl = 1'b0;
		else if (nc == 8'h01)
			lvl = 1'b1;
		true_next = lvl ^ inv;
	endfunction

	function automatic logic inv_next(input logic [7:0] cmp,
		input logic [7:0] top, input logic [7:0] nc, input logic cur);
		inv_next = cur;
		if (cmp == 8'h00)
			inv_next = 1'b1;
		else if (cmp == top)
			inv_next = 1'b0;
		else if (nc == cmp)
			inv_next = 1'b1;
		else if (nc == 8'h00)
			inv_next = 1'b0;
	endfunction

	// New period starts on the new compares, else the pair overlaps
	assign eff_a = (tick && at_top) ? buf_a : compare_a_value;
	assign eff_b = (tick && at_top) ? buf_b : compare_b_value;

	// No dead time: at a match both outputs switch on the same edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pins_a <= '{1'b0, 1'b1, 1'b0, 1'b1};
			pins_b <= '{1'b0, 1'b1, 1'b0, 1'b1};
		end
		else
		begin
			pins_a.true_oe_n <= !chan_a.pwm_en || chan_a.mode == MODE_OFF;
			pins_a.inv_oe_n  <= !chan_a.pwm_en
				|| chan_a.mode != MODE_PAIR;
			pins_b.true_oe_n <= !chan_b.pwm_en || chan_b.mode == MODE_OFF;
			pins_b.inv_oe_n  <= !chan_b.pwm_en
				|| chan_b.mode != MODE_PAIR;
			if (tick && !cnt_written && chan_a.pwm_en)
			begin
				pins_a.true_out <= true_next(chan_a.mode, eff_a,
					top_compare_value, next_count, pins_a.true_out);
				pins_a.inv_out <= inv_next(eff_a,
					top_compare_value, next_count, pins_a.inv_out);
			end
			if (tick && !cnt_written && chan_b.pwm_en)
			begin
				pins_b.true_out <= true_next(chan_b.mode, eff_b,
					top_compare_value, next_count, pins_b.true_out);
				pins_b.inv_out <= inv_next(eff_b,
					top_compare_value, next_count, pins_b.inv_out);
			end
		end
	end

endmodule

// >>> verification/tpg_timer_chk.sv
`timescale 1ns/10ps
module tpg_chk
	import tpg_pkg::*;
(
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	// Ticks and core side
	input wire logic        sys_tick,
	input wire logic        pck_tick,
	input wire logic        global_irq_en,
	input wire logic        pll_is_sysclk,
	input wire logic        ack_ovf,
	input wire logic        ack_cmp_a,
	input wire logic        irq_ovf,
	input wire logic        irq_cmp_a,
	input wire logic        irq_cmp_b,
	// Watched outputs
	input wire logic        pll_run,
	input wire logic        pck_half_rate,
	input wire tpg_pins_t   pins_a,
	input wire tpg_pins_t   pins_b
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	ovf_gate_a:
	assert property (irq_ovf |-> global_irq_en) else $error("ovf gate");
	cmpa_gate_a:
	assert property (irq_cmp_a |-> global_irq_en) else $error("cmp a gate");
	cmpb_gate_a:
	assert property (irq_cmp_b |-> global_irq_en) else $error("cmp b gate");
	// Three quiet cycles so no synced event can re-arm the flag
	ovf_ack_a:
	assert property ((!sys_tick && !pck_tick)[*3] ##0 ack_ovf |=> !irq_ovf)
		else $error("ovf ack");
	cmpa_ack_a:
	assert property ((!sys_tick && !pck_tick)[*3] ##0 ack_cmp_a
		|=> !irq_cmp_a) else $error("cmp a ack");
	sysclk_pll_a:
	assert property (pll_is_sysclk |-> pll_run) else $error("pll run");
	half_hold_a:
	assert property (!(psel && penable && pwrite) |=> $stable(pck_half_rate))
		else $error("half rate moved");
	pins_hold_a:
	assert property (!(sys_tick || pck_tick || (psel && penable && pwrite))
		&& !$past(psel && penable && pwrite)
		|=> $stable(pins_a) && $stable(pins_b)) else $error("pins moved");
	pair_a_a:
	assert property (!pins_a.inv_oe_n |-> !pins_a.true_oe_n &&
		!(pins_a.inv_out && pins_a.true_out)) else $error("pair a");
	pair_b_a:
	assert property (!pins_b.inv_oe_n |-> !pins_b.true_oe_n &&
		!(pins_b.inv_out && pins_b.true_out)) else $error("pair b");
	upper_zero_a:
	assert property (prdata[31:8] == 24'h0) else $error("upper data");
endmodule

bind tpg_timer tpg_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.prdata, .sys_tick, .pck_tick, .global_irq_en, .pll_is_sysclk,
	.ack_ovf, .ack_cmp_a, .irq_ovf, .irq_cmp_a, .irq_cmp_b, .pll_run,
	.pck_half_rate, .pins_a, .pins_b);

// >>> verification/tpg_sw_model.sv
`timescale 1ns/10ps
module tpg_sw_model
	import tpg_pkg::*;
(
	// Gate drive
	input wire logic      pclk,
	input wire tpg_pins_t pins,
	// Switch state
	output logic          hi_on,
	output logic          lo_on,
	output int            shoot_cnt
);
	// Released gates fall through pull-downs
	assign hi_on = !pins.true_oe_n && pins.true_out;
	assign lo_on = !pins.inv_oe_n && pins.inv_out;
	initial shoot_cnt = 0;
	// Both switches on shorts the supply
	always @(posedge pclk)
		if (hi_on && lo_on)
			shoot_cnt++;
endmodule

// >>> verification/tpg_timer_tb.sv
`timescale 1ns/10ps
module tpg_timer_tb import tpg_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        sys_tick, pck_tick, global_irq_en, pll_is_sysclk;
	logic        ack_ovf, ack_cmp_a, ack_cmp_b, irq_ovf, irq_cmp_a;
	logic        irq_cmp_b, pll_run, pck_half_rate, sys_en, pck_en, err;
	wire  [1:0]  hi_on, lo_on;
	logic [7:0]  q, t, c;
	tpg_pins_t   pins_a, pins_b;
	int          fail_count, checks, shoot_a, shoot_b, hi, lo, n;

	tpg_timer #(.LOCK_CNT(20)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sys_tick,
		.pck_tick, .global_irq_en, .pll_is_sysclk, .ack_ovf, .ack_cmp_a,
		.ack_cmp_b, .irq_ovf, .irq_cmp_a, .irq_cmp_b, .pll_run,
		.pck_half_rate, .pins_a, .pins_b);
	tpg_sw_model i_sw_a (.pclk, .pins(pins_a), .hi_on(hi_on[0]),
		.lo_on(lo_on[0]), .shoot_cnt(shoot_a));
	tpg_sw_model i_sw_b (.pclk, .pins(pins_b), .hi_on(hi_on[1]),
		.lo_on(lo_on[1]), .shoot_cnt(shoot_b));

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	// Random fast ticks; system ticks every cycle for exact periods
	always @(posedge pclk)
	begin
		sys_tick <= sys_en;
		pck_tick <= pck_en && $urandom_range(1);
	end
	initial
	begin
		repeat (50000) @(posedge pclk);
		fail_count++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] s, e);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic run(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// Read data stands through access; taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] idx, d);
		psel <= 1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		q = prdata[7:0];
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] idx, e, input string nm);
		apb(0, idx, 8'h00);
		check(nm, q, e);
	endtask
	task automatic meas(input int ch, input int len);
		hi = 0;
		lo = 0;
		repeat (len)
		begin
			@(posedge pclk);
			hi += hi_on[ch];
			lo += lo_on[ch];
		end
	endtask
	function automatic int exp_hi(input int m, input int c, input int t);
		int h;
		h = (c == 0) ? 0 : (c == t) ? t + 1 : c - 1;
		if (m == 3)
			h = t + 1 - h;
		return (m == 0) ? 0 : h;
	endfunction
	// Inverse output is driven only in the paired mode
	function automatic int exp_lo(input int m, input int c, input int t);
		if (m != 1)
			return 0;
		return (c == 0) ? t + 1 : (c == t) ? 0 : t + 1 - c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, sys_en, pck_en} = '0;
		{global_irq_en, pll_is_sysclk, ack_ovf, ack_cmp_a, ack_cmp_b} = '0;
		{fail_count, checks} = '0;
		presetn = 0;
		void'($urandom(74460));
		run(3);
		presetn <= 1;
		rc(IDX_FLAGS, 8'h00, "flags_rst");
		rc(IDX_PLL_CSR, 8'h00, "csr_rst");
		apb(1, 8'h3F, 8'hA5);
		check("slverr", {7'h0, err}, 8'h01);
		rc(8'h3F, 8'h00, "unmapped");
		t = 8'($urandom_range(12, 4));
		apb(1, IDX_TOP, t);
		sys_en <= 1;
		for (int ch = 0; ch < 2; ch++)
			for (int m = 0; m < 4; m++)
				for (int j = 0; j < 3; j++)
				begin
					c = j == 0 ? 8'h00 : j == 2 ? t : 8'($urandom_range(t - 1, 2));
					apb(1, IDX_CTRL, ch ? 8'h08 | 8'(m) : 8'h40 | 8'(m << 4));
					apb(1, ch ? IDX_CMP_B : IDX_CMP_A, c);
					rc(ch ? IDX_CMP_B : IDX_CMP_A, c, "cmp_rb");
					run(2 * (t + 1));
					meas(ch, 3 * (t + 1));
					n = 3 * exp_hi(m, c, t);
					check("high", 8'(hi), 8'(n));
					check("low", 8'(lo), 8'(3 * exp_lo(m, c, t)));
				end
		apb(0, IDX_FLAGS, 8'h00);
		check("pwm_ovf", q & 8'h85, 8'h04);
		apb(1, IDX_MASK, 8'h64);
		global_irq_en <= 1;
		run(2);
		check("irq", {7'h0, irq_ovf}, 8'h01);
		sys_en <= 0;
		run(4);
		apb(1, IDX_FLAGS, 8'h64);
		rc(IDX_FLAGS, 8'h00, "w1c");
		sys_en <= 1;
		run(30);
		sys_en <= 0;
		run(4);
		{ack_ovf, ack_cmp_a, ack_cmp_b} <= 3'h7;
		run(1);
		{ack_ovf, ack_cmp_a, ack_cmp_b} <= 3'h0;
		run(2);
		apb(0, IDX_FLAGS, 8'h00);
		check("ack", q & 8'h64, 8'h00);
		apb(1, IDX_CTRL, 8'h80);
		apb(1, IDX_TOP, 8'h0A);
		apb(1, IDX_COUNTER, 8'h00);
		apb(1, IDX_FLAGS, 8'h64);
		sys_en <= 1;
		run(300);
		apb(0, IDX_FLAGS, 8'h00);
		check("ctc", q & 8'h04, 8'h00);
		apb(1, IDX_CTRL, 8'h00);
		run(300);
		apb(0, IDX_FLAGS, 8'h00);
		check("wrap", q & 8'h04, 8'h04);
		apb(1, IDX_CTRL, 8'h40);
		apb(1, IDX_FLAGS, 8'h64);
		sys_en <= 0;
		pck_en <= 1;
		run(100);
		apb(0, IDX_FLAGS, 8'h00);
		check("sync_src", q & 8'h04, 8'h00);
		pck_en <= 0;
		apb(1, IDX_PLL_CSR, 8'h04);
		rc(IDX_PLL_CSR, 8'h00, "fast_refused");
		apb(1, IDX_PLL_CSR, 8'h02);
		rc(IDX_PLL_CSR, 8'h02, "not_locked");
		run(20);
		n = 0;
		do apb(0, IDX_PLL_CSR, 8'h00); while (q[0] !== 1'b1 && ++n < 50);
		apb(1, IDX_PLL_CSR, 8'hFE);
		rc(IDX_PLL_CSR, 8'h87, "csr");
		check("half", {7'h0, pck_half_rate}, 8'h01);
		apb(1, IDX_COUNTER, 8'h00);
		pck_en <= 1;
		run(200);
		apb(0, IDX_FLAGS, 8'h00);
		check("fast_src", q & 8'h04, 8'h04);
		pck_en <= 0;
		pll_is_sysclk <= 1;
		apb(1, IDX_PLL_CSR, 8'h00);
		apb(0, IDX_PLL_CSR, 8'h00);
		check("pll_sys", q & 8'h02, 8'h02);
		check("shoot", 8'(shoot_a + shoot_b), 8'h00);
		report_and_stop();
	end
endmodule
